/* verification/pulse_source.sv */
// ========================================
// External pulse source on the timer input
module pulse_source (
  // Clock
  input wire logic clk,
  // Pin toward the timer
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pin idles low until the bench asks for a level
  initial pin = 1'b0;

  // Holds one level for a number of clock cycles, changed just after an edge
  task automatic drive(input logic lvl, input int cycles);
    pin <= lvl;
    repeat (cycles) @(posedge clk);
  endtask
endmodule

/* verification/tb_width_counter.sv */
`include "width_counter_map.svh"
// ========================================
// Self-checking bench of the width counter
module tb_width_counter;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0; // 50 MHz system clock
  logic rst_n; // Synchronous reset, active low
  logic [7:0] address; // Bus address
  logic read; // Bus read request
  logic write; // Bus write request
  logic [31:0] writedata; // Bus write data
  logic [3:0] byteenable; // All lanes always on
  logic [31:0] readdata; // Bus read data
  logic waitrequest; // Bus stall
  logic pin; // Timer input from the source model
  logic channel_interrupt; // Interrupt pulse
  int num_errors = 0; // Mismatch count
  int n_tests = 0; // Comparison count
  int irq_cnt = 0; // Interrupt pulses seen
  int cycles = 0; // Watchdog count
  int mdl; // Model of the accumulated width in ticks
  int k; // Interrupt count snapshot
  logic [31:0] rd; // Last read value
  logic [31:0] rd2; // Earlier read value
  logic [7:0] zero_ofs [7] = '{`OFS_MODE, `OFS_EDGE, `OFS_DATA, `OFS_COUNT,
                              `OFS_STATUS, `OFS_ENABLE, 8'h30};

  width_counter i_width_counter (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timer_input_pin(pin), .channel_interrupt(channel_interrupt));
  pulse_source i_pulse_source (.clk(clk), .pin(pin));

  // ========================================
  // Clock, interrupt monitor and watchdog
  initial begin
    forever #10 clk = ~clk;
  end

  // Counts interrupt pulses and cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (channel_interrupt === 1'b1) begin
      irq_cnt++;
    end
    if (cycles == 100000) begin
      num_errors++;
      results();
    end
  end

  // ========================================
  // Comparison and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Allows one operation clock of pin sampling skew
  task automatic check_near(input logic [31:0] seen, input logic [31:0] exp);
    logic [31:0] d;
    d = seen - exp;
    check(seen, (^d !== 1'bx && (d == 0 || d == 1 || d == 32'hFFFFFFFF)) ? seen : exp);
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdreg(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // Waits for the next interrupt pulse, bounded by the watchdog
  task automatic wait_irq(input int n);
    while (irq_cnt < n) begin
      @(posedge clk);
    end
  endtask

  // Measures one pulse of n clocks, div clocks per tick, against the model
  task automatic measure(input logic lvl, input int n, input int div);
    k = irq_cnt;
    i_pulse_source.drive(lvl, n);
    i_pulse_source.drive(~lvl, 2);
    wait_irq(k + 1);
    mdl = mdl + n / div;
    rdreg(`OFS_DATA);
    rd2 = rd;
    check_near(rd2, mdl - 1);
    rdreg(`OFS_COUNT);
    check(rd, rd2 + 1);
  endtask

  // Stops, then starts the channel afresh
  task automatic restart();
    wreg(`OFS_STOP, 32'h1);
    wreg(`OFS_START, 32'h1);
    mdl = 0;
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    k = $urandom(32'hF8AF);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped place reads zero
    foreach (zero_ofs[i]) begin
      rdreg(zero_ofs[i]);
      check(rd, 32'h0);
    end
    // Capture mode, high width, two pulses accumulate
    wreg(`OFS_EDGE, 32'h3);
    wreg(`OFS_MODE, 32'h045A);
    wreg(`OFS_START, 32'h1);
    rdreg(`OFS_ENABLE);
    check(rd, 32'h1);
    rdreg(`OFS_START);
    check(rd, 32'h0);
    check(irq_cnt, 0);
    mdl = 0;
    measure(1'b1, 20, 1);
    measure(1'b1, 10, 1);
    // Stopped channel holds and ignores pin edges
    wreg(`OFS_STOP, 32'h1);
    rdreg(`OFS_ENABLE);
    check(rd, 32'h0);
    rdreg(`OFS_COUNT);
    rd2 = rd;
    k = irq_cnt;
    i_pulse_source.drive(1'b1, 12);
    i_pulse_source.drive(1'b0, 6);
    rdreg(`OFS_COUNT);
    check(rd, rd2);
    check(irq_cnt, k);
    // Low width with random pulses, each after a restart from zero
    wreg(`OFS_EDGE, 32'h2);
    i_pulse_source.drive(1'b1, 3);
    for (int i = 0; i < 3; i++) begin
      restart();
      measure(1'b0, 4 + $urandom % 40, 1);
    end
    // Every clock select, four ticks of high width each
    wreg(`OFS_EDGE, 32'h3);
    i_pulse_source.drive(1'b0, 3);
    for (int c = 0; c < 4; c++) begin
      wreg(`OFS_STOP, 32'h1);
      wreg(`OFS_MODE, 32'h045A | (c << 14));
      restart();
      measure(1'b1, 4 << (2 * c), 1 << (2 * c));
    end
    // Overflow past full scale, read while running
    wreg(`OFS_MODE, 32'h045A);
    restart();
    k = irq_cnt;
    fork
      i_pulse_source.drive(1'b1, 65540);
      begin
        repeat (200) @(posedge clk);
        rdreg(`OFS_COUNT);
        rd2 = rd;
        rdreg(`OFS_COUNT);
        check_near(rd - rd2, 3);
      end
    join
    i_pulse_source.drive(1'b0, 2);
    wait_irq(k + 1);
    rdreg(`OFS_DATA);
    check_near(rd, 65540 - 1 - 65536);
    rdreg(`OFS_STATUS);
    check(rd, 32'h1);
    wreg(`OFS_STOP, 32'h1);
    rdreg(`OFS_STATUS);
    check(rd, 32'h1);
    wreg(`OFS_CLEAR, 32'h1);
    rdreg(`OFS_STATUS);
    check(rd, 32'h0);
    // Gate mode, count down from full scale with a pause
    wreg(`OFS_DATA, 32'hFFFF);
    wreg(`OFS_MODE, 32'h0418);
    wreg(`OFS_START, 32'h1);
    k = irq_cnt;
    // Start and stop ticks do not count down, so a pulse of n ticks removes n - 1
    i_pulse_source.drive(1'b1, 10);
    i_pulse_source.drive(1'b0, 8);
    rdreg(`OFS_COUNT);
    check_near(rd, 32'hFFFF - 9);
    i_pulse_source.drive(1'b1, 6);
    i_pulse_source.drive(1'b0, 8);
    rdreg(`OFS_COUNT);
    check_near(rd, 32'hFFFF - 14);
    check(irq_cnt, k);
    // Start interrupt only when asked for, stopped before restart
    wreg(`OFS_STOP, 32'h1);
    wreg(`OFS_MODE, 32'h0419);
    k = irq_cnt;
    wreg(`OFS_START, 32'h1);
    repeat (4) @(posedge clk);
    check(irq_cnt, k + 1);
    results();
  end
endmodule

/* verilog/edge_evt_if.sv */
// ========================================
// Sampled pin events on the operation clock
interface edge_evt_if;
  logic tick; // Operation clock enable pulse
  logic rise; // Rising edge seen at a tick
  logic fall; // Falling edge seen at a tick
  modport det (output tick, output rise, output fall);
  modport use_side (input tick, input rise, input fall);
endinterface

/* verilog/op_clock_gen.sv */
// ========================================
// Four prescaled enables, one selected
module op_clock_gen #(
  parameter int EXP_A = 0,
  parameter int EXP_B = 2,
  parameter int EXP_C = 4,
  parameter int EXP_D = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Selection and tick
  input wire logic [1:0] sel,
  output logic tick
);
  logic [7:0] div_q; // Free running divider
  logic tick_q; // Selected enable

  // True once every 2**e cycles
  function automatic logic tick_of(input logic [7:0] c, input int e);
    logic [7:0] m;
    m = 8'((32'h1 << e) - 32'h1);
    return &(c | ~m);
  endfunction

  // Divider counts every cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Pick the operation clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      unique case (sel)
        2'h0: tick_q <= tick_of(div_q, EXP_A);
        2'h1: tick_q <= tick_of(div_q, EXP_B);
        2'h2: tick_q <= tick_of(div_q, EXP_C);
        2'h3: tick_q <= tick_of(div_q, EXP_D);
      endcase
    end
  end

  assign tick = tick_q;
endmodule

/* verilog/pin_edge_detect.sv */
// ========================================
// Pin synchroniser and edge detector
module pin_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and enable
  input wire logic pin,
  input wire logic tick,
  // Events out
  edge_evt_if.det evt
);
  logic s1_q, s2_q; // Two-flop synchroniser
  logic samp_q; // Last sample at a tick
  logic tick_q, rise_q, fall_q; // Aligned events

  // Bring the pin into the clock domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  // Sample only on the operation clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_q <= 1'b0;
      tick_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      tick_q <= tick;
      rise_q <= tick && s2_q && !samp_q;
      fall_q <= tick && !s2_q && samp_q;
      if (tick) begin
        samp_q <= s2_q;
      end
    end
  end

  assign evt.tick = tick_q;
  assign evt.rise = rise_q;
  assign evt.fall = fall_q;

  // Edges only appear with a tick
  edge_on_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rise_q || fall_q) |-> tick_q && !(rise_q && fall_q))
    else $error("edge pulse outside operation tick");
endmodule

/* verilog/width_counter.sv */
// Chosen here: register access over Avalon-MM and the register offsets.
`include "width_counter_map.svh"
module width_counter
  import width_counter_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timer pin and event
  input wire logic timer_input_pin,
  output logic channel_interrupt
);
  // ========================================
  // Declarations
  logic waitrequest_q; // Bus stall, low one cycle
  logic [31:0] readdata_q; // Latched read word
  logic [31:0] rdata_d; // Read mux
  logic [15:0] mode_q; // Channel mode config
  logic [1:0] edgecfg_q; // Edge select field
  count_t cdr_q; // Channel data register
  count_t cnt_q; // Channel counter
  logic ovf_q; // Overflow flag
  logic enable_q; // Channel enable status
  chan_state_t state_q; // Sequencing state
  logic irq_q; // Interrupt pulse
  logic acc; // Request accepted this edge
  logic wr_acc; // Write accepted this edge
  logic start_wr; // Start trigger written
  logic stop_wr; // Stop trigger written
  logic clr_wr; // Overflow clear written
  logic [3:0] md; // Operation mode field
  logic cap_mode; // Capture-and-gate selected
  logic gate_mode; // Gate-count selected
  logic start_ev; // Valid start edge
  logic stop_ev; // Valid stop edge
  logic cap_ev; // Capture this cycle
  logic wrap_ev; // Up-count wraps at full
  logic under_ev; // Down-count hits zero
  logic op_tick; // Operation clock pulse

  edge_evt_if evt ();

  // ========================================
  // Helpers
  // Merge bytes of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Is a trigger bit written to one; every operand is an argument so callers re-evaluate
  function automatic logic trig_hit(input logic hit, input logic [7:0] a,
                                    input logic [7:0] ofs, input logic [3:0] be,
                                    input logic [31:0] wd);
    return hit && (a == ofs) && be[0] && wd[`TRIG_BIT];
  endfunction

  // ========================================
  // Operation clock and pin edges
  op_clock_gen u_clk (
    .clk(clk),
    .rst_n(rst_n),
    .sel(mode_q[`CKS_MSB:`CKS_LSB]),
    .tick(op_tick)
  );

  pin_edge_detect u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pin(timer_input_pin),
    .tick(op_tick),
    .evt(evt)
  );

  // ========================================
  // Bus slave
  // Accept at the edge where waitrequest is low
  assign acc = (read || write) && !waitrequest_q;
  assign wr_acc = write && acc;
  assign start_wr = trig_hit(wr_acc, address, `OFS_START, byteenable, writedata);
  assign stop_wr = trig_hit(wr_acc, address, `OFS_STOP, byteenable, writedata);
  assign clr_wr = trig_hit(wr_acc, address, `OFS_CLEAR, byteenable, writedata);

  // One wait cycle, then a single-cycle answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest_q <= 1'b1;
    end else if ((read || write) && waitrequest_q) begin
      waitrequest_q <= 1'b0;
    end else begin
      waitrequest_q <= 1'b1;
    end
  end

  // Read mux; trigger and clear words read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (address)
      `OFS_MODE: rdata_d[15:0] = mode_q;
      `OFS_EDGE: rdata_d[1:0] = edgecfg_q;
      `OFS_DATA: rdata_d[15:0] = cdr_q;
      `OFS_COUNT: rdata_d[15:0] = cnt_q;
      `OFS_STATUS: rdata_d[0] = ovf_q;
      `OFS_ENABLE: rdata_d[0] = enable_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data captured while stalled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (read && waitrequest_q) begin
      readdata_q <= rdata_d;
    end
  end

  // ========================================
  // Configuration registers
  // Mode and edge select written by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= `RST_MODE;
      edgecfg_q <= `RST_EDGE;
    end else if (wr_acc) begin
      if (address == `OFS_MODE) begin
        mode_q <= merge16(mode_q, writedata, byteenable);
      end
      if (address == `OFS_EDGE && byteenable[0]) begin
        edgecfg_q <= writedata[1:0];
      end
    end
  end

  // ========================================
  // Mode and edge decoding
  assign md = mode_q[`MD_MSB:`MD_LSB];
  assign cap_mode = (md == `MD_CAPGATE);
  assign gate_mode = (md == `MD_GATECNT);

  // Start and stop edges per edge select
  always_comb begin
    start_ev = 1'b0;
    stop_ev = 1'b0;
    if (edgecfg_q == `TIS_HIGH) begin
      start_ev = evt.rise;
      stop_ev = evt.fall;
    end else if (edgecfg_q == `TIS_LOW) begin
      start_ev = evt.fall;
      stop_ev = evt.rise;
    end
  end

  // Counting events in the running state
  assign cap_ev = (state_q == ST_COUNTING) && cap_mode && stop_ev;
  assign wrap_ev = (state_q == ST_COUNTING) && cap_mode &&
                   evt.tick && (cnt_q == `CNT_FULL);
  assign under_ev = (state_q == ST_COUNTING) && gate_mode &&
                    evt.tick && !stop_ev && (cnt_q == `CNT_ZERO);

  // ========================================
  // Channel sequencing
  // Enable follows the triggers; stop wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
    end else if (stop_wr) begin
      enable_q <= 1'b0;
    end else if (start_wr) begin
      enable_q <= 1'b1;
    end
  end

  // State walks wait, count, pause
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_STOPPED;
    end else if (stop_wr) begin
      state_q <= ST_STOPPED;
    end else if (start_wr) begin
      state_q <= ST_WAIT_FIRST;
    end else begin
      unique case (state_q)
        ST_STOPPED: state_q <= ST_STOPPED;
        ST_WAIT_FIRST: begin
          if (start_ev && (cap_mode || gate_mode)) begin
            state_q <= ST_COUNTING;
          end
        end
        ST_COUNTING: begin
          if (stop_ev) begin
            state_q <= ST_PAUSED;
          end
        end
        ST_PAUSED: begin
          if (start_ev) begin
            state_q <= ST_COUNTING;
          end
        end
      endcase
    end
  end

  // ========================================
  // Counter
  // Holds unless loaded at the first start edge or counting at a tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= `CNT_ZERO;
    end else if (!stop_wr && !start_wr) begin
      unique case (state_q)
        ST_WAIT_FIRST: begin
          if (start_ev && cap_mode) begin
            cnt_q <= `CNT_ZERO;
          end else if (start_ev && gate_mode) begin
            cnt_q <= `CNT_FULL;
          end
        end
        ST_COUNTING: begin
          if (cap_mode && evt.tick) begin
            cnt_q <= cnt_q + `CNT_ONE;
          end else if (gate_mode && evt.tick && !stop_ev) begin
            if (under_ev) begin
              cnt_q <= `CNT_FULL;
            end else begin
              cnt_q <= cnt_q - `CNT_ONE;
            end
          end
        end
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // ========================================
  // Data register
  // Capture wins over a software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cdr_q <= `RST_DATA;
    end else if (cap_ev) begin
      cdr_q <= cnt_q;
    end else if (wr_acc && address == `OFS_DATA) begin
      cdr_q <= merge16(cdr_q, writedata, byteenable);
    end
  end

  // ========================================
  // Overflow flag
  // Set beats clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else if (wrap_ev) begin
      ovf_q <= 1'b1;
    end else if (clr_wr) begin
      ovf_q <= 1'b0;
    end
  end

  // ========================================
  // Interrupt
  // Pulse on capture, underflow, or start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= cap_ev || under_ev ||
               (start_wr && mode_q[`MD0_BIT]);
    end
  end

  // ========================================
  // Outputs
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign channel_interrupt = irq_q;

  // ========================================
  // Checks
  start_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_wr && !stop_wr |=> enable_q && state_q == ST_WAIT_FIRST)
    else $error("start trigger did not enable");

  first_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_WAIT_FIRST && start_ev && cap_mode && !start_wr && !stop_wr
    |=> cnt_q == `CNT_ZERO && state_q == ST_COUNTING)
    else $error("first start edge did not clear");

  resume_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_PAUSED && start_ev && !start_wr && !stop_wr
    |=> cnt_q == $past(cnt_q) && state_q == ST_COUNTING)
    else $error("resume lost the stop value");

  capture_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_ev && !start_wr && !stop_wr
    |=> cdr_q == $past(cnt_q) && irq_q && cnt_q == $past(cnt_q) + `CNT_ONE)
    else $error("capture wrong");

  pause_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_PAUSED && !start_ev && !start_wr |=> $stable(cnt_q))
    else $error("paused counter moved");

  wrap_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrap_ev && !start_wr && !stop_wr |=> ovf_q && cnt_q == `CNT_ZERO)
    else $error("overflow not flagged");

  stop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    stop_wr |=> !enable_q && $stable(cnt_q) ##1 $stable(cnt_q))
    else $error("stop did not hold counter");

  stopped_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_STOPPED && !start_wr |=> $stable(cnt_q) && !irq_q)
    else $error("stopped channel reacted");

  gate_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_WAIT_FIRST && start_ev && gate_mode && !start_wr && !stop_wr
    |=> cnt_q == `CNT_FULL)
    else $error("gate mode did not load full");

  underflow_a: assert property (@(posedge clk) disable iff (!rst_n)
    under_ev && !start_wr && !stop_wr |=> irq_q && cnt_q == `CNT_FULL)
    else $error("underflow missed");

  no_start_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_wr && !mode_q[`MD0_BIT] |=> !irq_q)
    else $error("start raised interrupt");

  ovf_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovf_q && !clr_wr |=> ovf_q)
    else $error("overflow flag dropped");
endmodule

/* verilog/width_counter_map.svh */
`ifndef WIDTH_COUNTER_MAP_SVH
`define WIDTH_COUNTER_MAP_SVH
// ========================================
// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_EDGE 8'h04
`define OFS_DATA 8'h08
`define OFS_COUNT 8'h0C
`define OFS_STATUS 8'h10
`define OFS_CLEAR 8'h14
`define OFS_START 8'h18
`define OFS_STOP 8'h1C
`define OFS_ENABLE 8'h20
// ========================================
// Reset values
`define RST_MODE 16'h0000
`define RST_EDGE 2'h0
`define RST_DATA 16'h0000
// ========================================
// Field positions
`define MD_MSB 4
`define MD_LSB 1
`define MD0_BIT 0
`define CKS_MSB 15
`define CKS_LSB 14
`define TRIG_BIT 0
// ========================================
// Counter values and codes
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_FULL 16'hFFFF
`define MD_CAPGATE 4'hD
`define MD_GATECNT 4'hC
`define TIS_LOW 2'h2
`define TIS_HIGH 2'h3
`endif

/* verilog/width_counter_pkg.sv */
// ========================================
// Shared types of the width counter
package width_counter_pkg;
  // Channel sequencing state
  typedef enum logic [1:0] {
    ST_STOPPED,
    ST_WAIT_FIRST,
    ST_COUNTING,
    ST_PAUSED
  } chan_state_t;
  // Counter word
  typedef logic [15:0] count_t;
endpackage
